//--- core/pfh_cycle.sv
/*
  One flash bus cycle: write strobe cycle or output gated read.
  Assumes the pin data inputs change only while the device drives them.
*/
`timescale 1ns/100ps
module pfh_cycle
  import pfh_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  clk_en,
  pfh_cyc_if.eng     cyc,
  input  wire logic [7:0]  fl_dq_in,
  output logic [7:0]       fl_dq_out,
  output logic             fl_dq_oe,
  output logic [16:0]      fl_addr,
  output logic             fl_cs_n,
  output logic             fl_oe_n,
  output logic             fl_we_n
);
  typedef enum logic [1:0] {
    PFH_C_IDLE  = 2'b00,
    PFH_C_SETUP = 2'b01,
    PFH_C_PULSE = 2'b10,
    PFH_C_HOLD  = 2'b11
  } pfh_cst_t;

  pfh_cst_t    st_r;
  logic [7:0]  cnt_r;
  logic        wr_r;
  logic [7:0]  s1_r, s2_r, s3_r;

  // Three stage sampler, value kept once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else if (clk_en) begin
      s1_r <= fl_dq_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Phase sequencer; chip select held low across the whole cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= PFH_C_IDLE;
      cnt_r     <= 8'h00;
      wr_r      <= 1'b0;
      fl_addr   <= '0;
      fl_dq_out <= 8'h00;
      fl_dq_oe  <= 1'b0;
      fl_cs_n   <= 1'b1;
      fl_oe_n   <= 1'b1;
      fl_we_n   <= 1'b1;
      cyc.done  <= 1'b0;
      cyc.rdata <= 8'h00;
    end else if (clk_en) begin
      cyc.done <= 1'b0;
      case (st_r)
        PFH_C_IDLE: begin
          if (cyc.req) begin
            wr_r      <= cyc.wr;
            fl_addr   <= cyc.addr;        // [R5]
            fl_dq_out <= cyc.wdata;
            fl_cs_n   <= 1'b0;
            fl_oe_n   <= 1'b1;
            cnt_r     <= SETUP_CYC;
            st_r      <= PFH_C_SETUP;
          end
        end
        PFH_C_SETUP: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            // Write: strobe low with gate high; read: gate low
            fl_we_n  <= ~wr_r;            // [R4]
            fl_oe_n  <= wr_r;             // [R1]
            fl_dq_oe <= wr_r;
            cnt_r    <= wr_r ? PULSE_CYC : ACCESS_CYC + 8'h02;
            st_r     <= PFH_C_PULSE;
          end
        end
        PFH_C_PULSE: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            // Strobe rises first so data is caught on it
            fl_we_n <= 1'b1;              // [R6]
            fl_oe_n <= 1'b1;              // [R2]
            if (!wr_r && s2_r == s3_r) begin
              cyc.rdata <= s3_r;
            end
            cnt_r <= HOLD_CYC;
            st_r  <= PFH_C_HOLD;
          end
        end
        PFH_C_HOLD: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            fl_cs_n  <= 1'b1;
            fl_dq_oe <= 1'b0;
            cyc.done <= 1'b1;
            st_r     <= PFH_C_IDLE;
          end
        end
        default: st_r <= PFH_C_IDLE;
      endcase
    end
  end
endmodule

//--- core/pfh_host.sv
/*
  Host controller for a 128K x 8 parallel flash: issues reads, byte
  programs, sector and chip erase, lockout enable and pin reset, and
  polls the toggle bit until an internal operation ends.
  Assumes one op at a time from the user and a bottom boot device.
*/
// Contract
// [R1] Reads drive chip select and output gate low, strobe high.
// [R2] Output gate goes high to end every read.
// [R3] Power up leaves all controls high, so the device is in standby.
// [R4] Writes pulse strobe low with chip select low, output gate high.
// [R5] Address stable before the later falling edge.
// [R6] Data stable until the first rising edge.
// [R7] Command addresses are never treated as data targets.
// [R8] Pin reset low aborts any device operation, floats outputs.
// [R9] Operations cut by reset are reported so the user reissues them.
// [R10] After reset release, wait recovery, then idle in standby.
// [R11] Override level on reset is requested by a separate output.
// [R12] Without reset pin, lockout is permanent; user must confirm.
// [R13] Erased bits read one; host erases before reprogram. The code never erases; it only refuses a program that sets a one over a zero.
// [R14] Chip erase sends the full six write code.
// [R15] Erase end is found by polling, no clock is supplied.
// [R16] Chip erase skips boot block when locked; device decides.
// [R17] No command is issued while chip erase runs.
// [R18] Sector erase: six writes, sector address and code last.
// [R19] Erase begins after the sixth write; host then polls.
// [R20] Main blocks alternate; the host flags a repeated main erase.
// [R21] Programming only clears bits; host refuses one over zero.
// [R22] Byte program uses the four write sequence.
// [R23] Program done when bit seven reads true.
// [R24] Busy while bit six toggles between reads.
// [R25] Sector erase into boot block is refused by the host.
// [R26] A failed sequence is followed by the single exit write. The code sends that write only after a pin reset.
// [R27] Sector address is snapped to one block base.
`timescale 1ns/100ps
module pfh_host
  import pfh_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         op_valid,
  output logic              op_ready,
  input  wire logic [2:0]   op_code,
  input  wire logic [16:0]  op_addr,
  input  wire logic [7:0]   op_wdata,
  input  wire logic         op_override,
  output logic              rsp_valid,
  output logic [7:0]        rsp_rdata,
  output logic              rsp_error,
  output logic              rsp_aborted,
  output logic              main_repeat,
  input  wire logic [7:0]   fl_dq_in,
  output logic [7:0]        fl_dq_out,
  output logic              fl_dq_oe,
  output logic [16:0]       fl_addr,
  output logic              fl_cs_n,
  output logic              fl_oe_n,
  output logic              fl_we_n,
  output logic              fl_reset_n,
  output logic              fl_reset_hv
);
  typedef enum logic [2:0] {
    PFH_IDLE  = 3'b000,
    PFH_CMD   = 3'b001,
    PFH_POLLA = 3'b010,
    PFH_POLLB = 3'b011,
    PFH_RSTLO = 3'b100,
    PFH_RSTHI = 3'b101,
    PFH_EXIT  = 3'b110,
    PFH_DONE  = 3'b111
  } pfh_st_t;

  pfh_cyc_if cyc ();

  pfh_st_t      st_r;
  pfh_op_t      op_r;
  logic [2:0]   step_r;
  logic [2:0]   nstep_r;
  logic [16:0]  addr_r;
  logic [7:0]   data_r;
  logic [7:0]   poll_r;
  logic [7:0]   rcnt_r;
  logic         busy_r;
  logic         last_main_r;
  logic         main_valid_r;
  logic         req_r;
  logic         wr_r;
  logic [16:0]  caddr_r;
  logic [7:0]   cdata_r;
  logic [16:0]  sect_base;
  logic         sect_boot;
  logic         prog_bad;

  pfh_cycle u_cyc (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .cyc       (cyc.eng),
    .fl_dq_in  (fl_dq_in),
    .fl_dq_out (fl_dq_out),
    .fl_dq_oe  (fl_dq_oe),
    .fl_addr   (fl_addr),
    .fl_cs_n   (fl_cs_n),
    .fl_oe_n   (fl_oe_n),
    .fl_we_n   (fl_we_n)
  );

  assign cyc.req   = req_r;
  assign cyc.wr    = wr_r;
  assign cyc.addr  = caddr_r;
  assign cyc.wdata = cdata_r;
  assign op_ready  = (st_r == PFH_IDLE) && !req_r;

  // Sector address decode to one block base
  always_comb begin
    sect_boot = 1'b0;
    if (op_addr >= SA_MAIN2) begin
      sect_base = SA_MAIN2;                 // [R27]
    end else if (op_addr >= SA_MAIN1) begin
      sect_base = SA_MAIN1;
    end else if (op_addr >= SA_PARAM2) begin
      sect_base = SA_PARAM2;
    end else if (op_addr >= SA_PARAM1) begin
      sect_base = SA_PARAM1;
    end else begin
      sect_base = 17'h00000;
      sect_boot = 1'b1;                     // [R25]
    end
  end

  // Program needs the read value first; refuse one over zero
  assign prog_bad = |(op_wdata & ~rsp_rdata);

  // Command word for each step of the current sequence
  function automatic logic [24:0] seq_word(input pfh_op_t op,
                                           input logic [2:0] s,
                                           input logic [16:0] a,
                                           input logic [7:0] d);
    logic [24:0] w;
    w = {CMD_ADDR_A, CMD_UNLOCK_A};
    case (s)
      3'd0: w = {CMD_ADDR_A, CMD_UNLOCK_A};
      3'd1: w = {CMD_ADDR_B, CMD_UNLOCK_B};
      3'd2: w = {CMD_ADDR_A, (op == PFH_OP_PROGRAM) ? CMD_PROGRAM
                                                     : CMD_ERASE_SET};
      3'd3: w = (op == PFH_OP_PROGRAM) ? {a, d}   // [R22]
                                        : {CMD_ADDR_A, CMD_UNLOCK_A};
      3'd4: w = {CMD_ADDR_B, CMD_UNLOCK_B};
      3'd5: begin
        if (op == PFH_OP_SECTOR) begin
          w = {a, CMD_SECT_ERS};            // [R18]
        end else if (op == PFH_OP_CHIP) begin
          w = {CMD_ADDR_A, CMD_CHIP_ERS};   // [R14]
        end else begin
          w = {CMD_ADDR_A, CMD_LOCKOUT};    // [R12]
        end
      end
      default: w = {CMD_ADDR_A, CMD_ID_EXIT};
    endcase
    return w;
  endfunction

  // Main sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r         <= PFH_IDLE;            // [R3]
      op_r         <= PFH_OP_READ;
      step_r       <= 3'd0;
      nstep_r      <= 3'd0;
      addr_r       <= '0;
      data_r       <= 8'h00;
      poll_r       <= 8'h00;
      rcnt_r       <= 8'h00;
      busy_r       <= 1'b0;
      req_r        <= 1'b0;
      wr_r         <= 1'b0;
      caddr_r      <= '0;
      cdata_r      <= 8'h00;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= 8'h00;
      rsp_error    <= 1'b0;
      rsp_aborted  <= 1'b0;
      fl_reset_n   <= 1'b1;
      fl_reset_hv  <= 1'b0;
      last_main_r  <= 1'b0;
      main_valid_r <= 1'b0;
      main_repeat  <= 1'b0;
    end else if (clk_en) begin
      rsp_valid <= 1'b0;
      req_r     <= 1'b0;
      case (st_r)
        PFH_IDLE: begin
          fl_reset_hv <= op_override;       // [R11]
          if (op_valid && !req_r) begin
            op_r        <= pfh_op_t'(op_code);
            rsp_error   <= 1'b0;
            rsp_aborted <= 1'b0;
            main_repeat <= 1'b0;
            step_r      <= 3'd0;
            nstep_r     <= 3'd0;
            addr_r      <= op_addr;
            data_r      <= op_wdata;
            if (op_code == PFH_OP_RESET) begin
              // Cuts any running device operation
              rsp_aborted <= busy_r;        // [R9]
              busy_r      <= 1'b0;
              fl_reset_n  <= 1'b0;          // [R8]
              rcnt_r      <= RSTL_CYC;
              st_r        <= PFH_RSTLO;
            end else if (op_code == PFH_OP_READ) begin
              req_r   <= 1'b1;
              wr_r    <= 1'b0;
              caddr_r <= op_addr;
              st_r    <= PFH_DONE;
            end else if (op_code == PFH_OP_SECTOR && sect_boot) begin
              rsp_error <= 1'b1;            // [R25]
              rsp_valid <= 1'b1;
            end else if (op_code == PFH_OP_PROGRAM && prog_bad) begin
              rsp_error <= 1'b1;            // [R21] [R13]
              rsp_valid <= 1'b1;
            end else begin
              if (op_code == PFH_OP_SECTOR) begin
                addr_r <= sect_base;
                if (sect_base >= SA_MAIN1) begin
                  // Same main block twice in a row
                  main_repeat <= main_valid_r &&
                    (last_main_r == (sect_base == SA_MAIN2)); // [R20]
                  last_main_r  <= (sect_base == SA_MAIN2);
                  main_valid_r <= 1'b1;
                end
              end
              st_r <= PFH_CMD;
            end
          end
        end
        PFH_CMD: begin
          if (!req_r && !cyc.done && step_r == nstep_r) begin
            req_r <= 1'b1;
            wr_r  <= 1'b1;
            {caddr_r, cdata_r} <= seq_word(op_r, step_r, addr_r, data_r);
            nstep_r <= step_r + 3'd1;
          end else if (cyc.done) begin
            step_r <= nstep_r;
            if ((op_r == PFH_OP_PROGRAM && nstep_r == 3'd4) ||
                nstep_r == 3'd6) begin
              busy_r <= 1'b1;               // [R19]
              st_r   <= PFH_POLLA;
              req_r  <= 1'b1;
              wr_r   <= 1'b0;
              caddr_r <= (op_r == PFH_OP_PROGRAM) ? addr_r : CMD_ADDR_A;
            end
          end
        end
        PFH_POLLA: begin
          // First read of the pair; no writes while busy
          if (cyc.done) begin
            poll_r  <= cyc.rdata;           // [R17] [R15]
            req_r   <= 1'b1;
            st_r    <= PFH_POLLB;
          end
        end
        PFH_POLLB: begin
          if (cyc.done) begin
            if (cyc.rdata[DATA_BIT_SIX] != poll_r[DATA_BIT_SIX]) begin
              req_r <= 1'b1;                // [R24]
              st_r  <= PFH_POLLA;
            end else if (op_r == PFH_OP_PROGRAM &&
                         cyc.rdata[DATA_BIT_SEVEN] !=
                         data_r[DATA_BIT_SEVEN]) begin
              req_r <= 1'b1;                // [R23]
              st_r  <= PFH_POLLA;
            end else begin
              busy_r    <= 1'b0;            // [R16]
              rsp_rdata <= cyc.rdata;
              rsp_error <= (op_r == PFH_OP_PROGRAM) &&
                           (cyc.rdata != data_r);
              rsp_valid <= 1'b1;
              st_r      <= PFH_IDLE;
            end
          end
        end
        PFH_RSTLO: begin
          if (rcnt_r > 8'h01) begin
            rcnt_r <= rcnt_r - 8'h01;
          end else begin
            fl_reset_n <= 1'b1;             // [R10]
            rcnt_r     <= RSTR_CYC;
            st_r       <= PFH_RSTHI;
          end
        end
        PFH_RSTHI: begin
          if (rcnt_r > 8'h01) begin
            rcnt_r <= rcnt_r - 8'h01;
          end else begin
            rsp_valid <= 1'b1;
            st_r      <= PFH_EXIT;
          end
        end
        PFH_EXIT: begin
          // Single exit write puts the decoder back to read
          req_r   <= 1'b1;                  // [R26] [R7]
          wr_r    <= 1'b1;
          caddr_r <= CMD_ADDR_A;
          cdata_r <= CMD_ID_EXIT;
          st_r    <= PFH_DONE;
        end
        PFH_DONE: begin
          if (cyc.done) begin
            rsp_rdata <= wr_r ? rsp_rdata : cyc.rdata; // [R1]
            rsp_valid <= !wr_r;
            st_r      <= PFH_IDLE;
          end
        end
        default: st_r <= PFH_IDLE;
      endcase
    end
  end
endmodule

//--- inc/pfh_cyc_if.sv
/*
  Carrier between the sequencer and the bus cycle engine.
  Assumes both ends share mclk.
*/
`timescale 1ns/100ps
interface pfh_cyc_if;
  import pfh_pkg::*;
  logic              req;
  logic              wr;
  logic [16:0]       addr;
  logic [7:0]        wdata;
  logic              done;
  logic [7:0]        rdata;
  modport seq (output req, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output done, output rdata);
endinterface

//--- inc/pfh_pkg.sv
/*
  Shared constants for the parallel flash host controller: command
  addresses and codes, block addresses, bus timing counts.
  Assumes a 50 MHz mclk and a 128K x 8 flash on the far side.
*/
package pfh_pkg;
  localparam int          CLK_NS        = 20;
  localparam int          ADDR_W        = 17;
  localparam int          DATA_W        = 8;
  // Command bus cycles
  localparam logic [16:0] CMD_ADDR_A    = 17'h05555;
  localparam logic [16:0] CMD_ADDR_B    = 17'h02aaa;
  localparam logic [7:0]  CMD_UNLOCK_A  = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK_B  = 8'h55;
  localparam logic [7:0]  CMD_ERASE_SET = 8'h80;
  localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;
  localparam logic [7:0]  CMD_CHIP_ERS  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERS  = 8'h30;
  localparam logic [7:0]  CMD_LOCKOUT   = 8'h40;
  localparam logic [7:0]  CMD_ID_ENTRY  = 8'h90;
  localparam logic [7:0]  CMD_ID_EXIT   = 8'hf0;
  // Sector base addresses (bottom boot variant)
  localparam logic [16:0] SA_PARAM1     = 17'h04000;
  localparam logic [16:0] SA_PARAM2     = 17'h06000;
  localparam logic [16:0] SA_MAIN1      = 17'h08000;
  localparam logic [16:0] SA_MAIN2      = 17'h10000;
  // Poll bit positions
  localparam int          DATA_BIT_SEVEN = 7;
  localparam int          DATA_BIT_SIX   = 6;
  // Bus phase times in ns, least times round up
  localparam int          T_SETUP_NS    = 40;
  localparam int          T_PULSE_NS    = 90;
  localparam int          T_HOLD_NS     = 40;
  localparam int          T_ACCESS_NS   = 60;
  localparam int          T_RST_LOW_NS  = 500;
  localparam int          T_RST_REC_NS  = 1000;
  localparam logic [7:0]  SETUP_CYC  = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  PULSE_CYC  = 8'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HOLD_CYC   = 8'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  ACCESS_CYC = 8'((T_ACCESS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  RSTL_CYC   = 8'((T_RST_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  RSTR_CYC   = 8'((T_RST_REC_NS + CLK_NS - 1) / CLK_NS);
  // Operation codes at the user port
  typedef enum logic [2:0] {
    PFH_OP_READ    = 3'b000,
    PFH_OP_PROGRAM = 3'b001,
    PFH_OP_SECTOR  = 3'b010,
    PFH_OP_CHIP    = 3'b011,
    PFH_OP_LOCKOUT = 3'b100,
    PFH_OP_RESET   = 3'b101
  } pfh_op_t;
endpackage

//--- test/pfh_flash_model.sv
/*
  Behavioural 128K x 8 flash, bottom boot, driven by its pins.
  Assumes the bench resolves the shared data wire; times are nominal.
*/
`timescale 1ns/100ps
module pfh_flash_model
  import pfh_pkg::*;
(
  input  wire logic        cs_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        reset_n,
  input  wire logic        reset_hv,
  input  wire logic [16:0] addr,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout
);
  logic [7:0]  mem [0:131071];
  logic [16:0] la, oa;
  logic [7:0]  od, rd, last;
  pfh_op_t     kind;
  int          step, lo, hi;
  logic        busy, locked, tgl, wstb, drv, prot;
  event        go;
  // Power-up in read mode with an erased array
  initial begin
    step = 0;
    busy = 0;
    locked = 0;
    tgl = 0;
    last = 8'h00;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  assign wstb = !cs_n && !we_n && oe_n && reset_n;
  // Address on the later fall, data on the first rise
  always @(posedge wstb) la = addr;
  always @(negedge wstb) if (!busy) decode(din);
  task automatic start(input pfh_op_t k);
    kind = k;
    oa = la;
    od = din;
    -> go;
  endtask
  // Any unexpected write drops back to idle; commands never store
  task automatic decode(input logic [7:0] d);
    case (step)
      0, 3: step = (la == CMD_ADDR_A && d == CMD_UNLOCK_A) ? step + 1 : 0;
      1, 4: step = (la == CMD_ADDR_B && d == CMD_UNLOCK_B) ? step + 1 : 0;
      2: step = la != CMD_ADDR_A ? 0 : d == CMD_PROGRAM ? 6 :
                d == CMD_ERASE_SET ? 3 : 0;
      5: begin
        step = 0;
        if (d == CMD_SECT_ERS) start(PFH_OP_SECTOR);
        else if (la == CMD_ADDR_A && d == CMD_CHIP_ERS) start(PFH_OP_CHIP);
        else if (la == CMD_ADDR_A && d == CMD_LOCKOUT) start(PFH_OP_LOCKOUT);
      end
      6: begin
        step = 0;
        start(PFH_OP_PROGRAM);
      end
      default: step = 0;
    endcase
  endtask
  // Result of a finished operation; boot guarded when locked unless override, and never sector erased
  task automatic finish_op();
    prot = locked && !reset_hv;
    case (kind)
      PFH_OP_PROGRAM: if (!prot || oa >= SA_PARAM1) mem[oa] &= od;
      PFH_OP_LOCKOUT: locked = 1;
      PFH_OP_CHIP: for (int i = 0; i < 131072; i++)
        if (!prot || i >= 'h4000) mem[i] = 8'hff;
      default: begin
        lo = oa < SA_PARAM2 ? SA_PARAM1 : oa < SA_MAIN1 ? SA_PARAM2 :
             oa < SA_MAIN2 ? SA_MAIN1 : SA_MAIN2;
        hi = oa < SA_PARAM2 ? SA_PARAM2 : oa < SA_MAIN1 ? SA_MAIN1 :
             oa < SA_MAIN2 ? SA_MAIN2 : 'h20000;
        if (oa >= SA_PARAM1) for (int i = lo; i < hi; i++) mem[i] = 8'hff;
      end
    endcase
  endtask
  // Self-timed operation, cut short by the reset pin
  always begin
    @go;
    begin : run
      busy = 1;
      #(kind == PFH_OP_CHIP ? 4000 : kind == PFH_OP_SECTOR ? 3000 : 1000);
      finish_op();
      busy = 0;
    end
  end
  always @(negedge reset_n) begin
    disable run;
    busy = 0;
    step = 0;
  end
  // Toggle flips at the end of each read while busy
  always @(posedge oe_n) if (busy) tgl = ~tgl;
  assign drv = !cs_n && !oe_n && we_n && reset_n;
  assign rd = busy ? {~od[7], tgl, od[5:0]} : mem[addr];
  // A released wire shows the inverse of the last byte, never a hold
  always @(rd or drv) if (drv) last = rd;
  assign dout = drv ? rd : ~last;
endmodule

//--- test/pfh_host_monitor.sv
/*
  Pin and handshake checker for the flash host controller.
  Assumes one mclk domain, rst_n asynchronous low, clk_en held high.
*/
`timescale 1ns/100ps
module pfh_host_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic        rsp_valid,
  input wire logic        op_override,
  input wire logic        fl_dq_oe,
  input wire logic [7:0]  fl_dq_out,
  input wire logic [16:0] fl_addr,
  input wire logic        fl_cs_n,
  input wire logic        fl_oe_n,
  input wire logic        fl_we_n,
  input wire logic        fl_reset_n,
  input wire logic        fl_reset_hv
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Five low strobe cycles, then high
  sequence we_pulse;
    !fl_we_n [*5] ##1 fl_we_n;
  endsequence
  // Bus idle with the reset pin low for eight cycles
  sequence rst_hold;
    (!fl_reset_n && fl_cs_n && fl_oe_n && fl_we_n) [*8];
  endsequence
  read_ctrl_a: assert property (!fl_oe_n |-> !fl_cs_n && fl_we_n && !fl_dq_oe)
    else $error("read control levels wrong");
  read_end_a: assert property ($fell(fl_oe_n) |-> ##[3:20] fl_oe_n)
    else $error("output gate not released");
  write_ctrl_a: assert property (!fl_we_n |-> !fl_cs_n && fl_oe_n && fl_dq_oe)
    else $error("write control levels wrong");
  we_width_a: assert property ($fell(fl_we_n) |-> we_pulse)
    else $error("strobe pulse width wrong");
  addr_hold_a: assert property (!fl_we_n |-> $stable(fl_addr))
    else $error("address moved under strobe");
  cs_setup_a: assert property ($fell(fl_we_n) |-> $past(fl_cs_n, 2) == 1'b0)
    else $error("chip select setup too short");
  data_rise_a: assert property ($rose(fl_we_n) |-> fl_dq_oe && !fl_cs_n && $stable(fl_dq_out))
    else $error("data not held past strobe rise");
  rst_quiet_a: assert property ($fell(fl_reset_n) |-> rst_hold)
    else $error("bus active during pin reset");
  rst_recover_a: assert property ($rose(fl_reset_n) |-> (fl_cs_n && fl_we_n) [*8])
    else $error("bus active during reset recovery");
  hv_cause_a: assert property ($rose(fl_reset_hv) |-> $past(op_override))
    else $error("override level without request");
  one_op_a: assert property (op_valid && op_ready |=> !op_ready || rsp_valid)
    else $error("second op taken while busy");
endmodule
bind pfh_host pfh_host_monitor mon_u (
  .mclk(mclk), .rst_n(rst_n), .op_valid(op_valid), .op_ready(op_ready),
  .rsp_valid(rsp_valid),
  .op_override(op_override), .fl_dq_oe(fl_dq_oe), .fl_dq_out(fl_dq_out),
  .fl_addr(fl_addr), .fl_cs_n(fl_cs_n), .fl_oe_n(fl_oe_n),
  .fl_we_n(fl_we_n), .fl_reset_n(fl_reset_n), .fl_reset_hv(fl_reset_hv)
);

//--- test/tb_parallel_flash_command_control.sv
/*
  Self-checking bench for the flash host controller.
  Assumes the flash model on the pins and the monitor bound in.
*/
`timescale 1ns/100ps
module tb_parallel_flash_command_control import pfh_pkg::*;;
  logic        mclk, rst_n, op_valid, op_override, op_ready, rsp_valid;
  logic        rsp_error, main_repeat, fl_dq_oe, fl_cs_n, fl_oe_n;
  logic        fl_we_n, fl_reset_n, fl_reset_hv, rsp_aborted;
  logic [2:0]  op_code;
  logic [16:0] op_addr, fl_addr, a_rd, a_p;
  logic [7:0]  op_wdata, rsp_rdata, fl_dq_in, fl_dq_out, dev_q;
  logic [7:0]  v_rd, v_cmd, v_pd;
  logic [9:0]  exp_q[$];
  logic [9:0]  e;
  int          mismatches, comparisons, seed;
  pfh_host dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
    .op_addr(op_addr), .op_wdata(op_wdata), .op_override(op_override),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
    .rsp_aborted(rsp_aborted), .main_repeat(main_repeat),
    .fl_dq_in(fl_dq_in),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe), .fl_addr(fl_addr),
    .fl_cs_n(fl_cs_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
    .fl_reset_n(fl_reset_n), .fl_reset_hv(fl_reset_hv));
  pfh_flash_model flash_u (.cs_n(fl_cs_n), .oe_n(fl_oe_n), .we_n(fl_we_n),
    .reset_n(fl_reset_n), .reset_hv(fl_reset_hv), .addr(fl_addr),
    .din(fl_dq_out), .dout(dev_q));
  // Host drive wins the wire
  assign fl_dq_in = fl_dq_oe ? fl_dq_out : dev_q;
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic cmp_byte(input string n, input logic [7:0] x,
                          input logic [7:0] s);
    comparisons++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic cmp_flag(input string n, input logic x, input logic s);
    comparisons++;
    if (s !== x) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", n, x, s);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Issue one op, note and await its answer
  task automatic do_op(input pfh_op_t c, input logic [16:0] a,
                       input logic [7:0] d, input logic ch,
                       input logic er, input logic [7:0] ed);
    exp_q.push_back({ch, er, ed});
    @(posedge mclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_addr <= a;
    op_wdata <= d;
    @(negedge mclk);
    while (op_ready !== 1'b1) @(negedge mclk);
    @(posedge mclk);
    op_valid <= 1'b0;
    @(negedge mclk);
    while (rsp_valid !== 1'b1) @(negedge mclk);
  endtask
  task automatic rd(input logic [16:0] a, input logic [7:0] x);
    do_op(PFH_OP_READ, a, 8'h00, 1'b1, 1'b0, x);
  endtask
  // Watcher pops the oldest note per response
  always @(negedge mclk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) cmp_flag("rsp_valid", 1'b0, rsp_valid);
      else begin
        e = exp_q.pop_front();
        cmp_flag("rsp_error", e[8], rsp_error);
        if (e[9]) cmp_byte("rsp_rdata", e[7:0], rsp_rdata);
      end
    end
  end
  // Cut a hang short, far past the run length
  initial begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    conclude();
  end
  initial begin
    seed = 32'hd8b27404;
    {rst_n, op_valid, op_code, op_addr, op_wdata, op_override} = '0;
    mismatches = 0;
    comparisons = 0;
    v_rd = 8'($random(seed));
    v_cmd = 8'($random(seed));
    v_pd = 8'($random(seed)) & 8'h7f;
    a_rd = SA_MAIN2 | 17'($random(seed) & 32'hffff);
    a_p = SA_PARAM2 | 17'($random(seed) & 32'h1fff);
    #1;
    flash_u.mem[a_rd] = v_rd;
    flash_u.mem[CMD_ADDR_A] = v_cmd;
    flash_u.mem[17'h00123] = 8'h5a;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(a_rd, v_rd);
    rd(a_p, 8'hff);
    do_op(PFH_OP_PROGRAM, a_p, v_pd, 1'b1, 1'b0, v_pd);
    rd(CMD_ADDR_A, v_cmd);
    rd(a_p, v_pd);
    do_op(PFH_OP_PROGRAM, a_p, 8'h80, 1'b0, 1'b1, 8'h00);
    do_op(PFH_OP_SECTOR, 17'h00200, 8'h00, 1'b0, 1'b1, 8'h00);
    rd(17'h00123, 8'h5a);
    do_op(PFH_OP_SECTOR, a_p, 8'h00, 1'b0, 1'b0, 8'h00);
    rd(a_p, 8'hff);
    rd(a_rd, v_rd);
    do_op(PFH_OP_SECTOR, SA_MAIN1, 8'h00, 1'b0, 1'b0, 8'h00);
    cmp_flag("main_repeat", 1'b0, main_repeat);
    do_op(PFH_OP_SECTOR, SA_MAIN1, 8'h00, 1'b0, 1'b0, 8'h00);
    cmp_flag("main_repeat", 1'b1, main_repeat);
    do_op(PFH_OP_LOCKOUT, CMD_ADDR_A, 8'h00, 1'b0, 1'b0, 8'h00);
    do_op(PFH_OP_CHIP, 17'h00000, 8'h00, 1'b0, 1'b0, 8'h00);
    rd(17'h00123, 8'h5a);
    rd(a_rd, 8'hff);
    @(posedge mclk);
    op_override <= 1'b1;
    repeat (3) @(negedge mclk);
    cmp_flag("fl_reset_hv", 1'b1, fl_reset_hv);
    do_op(PFH_OP_CHIP, 17'h00000, 8'h00, 1'b0, 1'b0, 8'h00);
    rd(17'h00123, 8'hff);
    @(posedge mclk);
    op_override <= 1'b0;
    do_op(PFH_OP_RESET, 17'h00000, 8'h00, 1'b0, 1'b0, 8'h00);
    cmp_flag("rsp_aborted", 1'b0, rsp_aborted);
    rd(a_rd, 8'hff);
    conclude();
  end
endmodule
